// ### logic/nv_consts.svh
// Offsets, field positions, the erased word value and timing for the nonvolatile
// self-access block. Assumes an 8-bit APB byte address, 32-bit data.
`ifndef NV_CONSTS_SVH
`define NV_CONSTS_SVH

// Register byte offsets, one aligned word each
`define NV_OFS_DATA_LOW   8'h00
`define NV_OFS_DATA_HIGH  8'h04
`define NV_OFS_ADDR_LOW   8'h08
`define NV_OFS_ADDR_HIGH  8'h0c
`define NV_OFS_CONTROL    8'h10
`define NV_OFS_UNLOCK     8'h14
`define NV_OFS_FLAG2      8'h18
`define NV_OFS_ENABLE2    8'h1c

// Control register fields
`define NV_CTL_RD_START   0
`define NV_CTL_WR_START   1
`define NV_CTL_GATE       2
`define NV_CTL_ABORT_ERR  3
`define NV_CTL_ERASE      4
`define NV_CTL_SPACE      7

// Completion flag and its enable, same position in both registers
`define NV_DONE_BIT       4

// Unlock key pair, written in this order
`define NV_KEY_FIRST      8'h55
`define NV_KEY_SECOND     8'haa

// Array geometry and values
`define NV_ROW_WORDS      32
`define NV_BLOCK_WORDS    4
`define NV_ERASED_WORD    14'h3fff
`define NV_DATA_WIDTH     8
`define NV_PWORD_WIDTH    14

// Self-timed write: time in ns and the clock period in ns
`define NV_WRITE_TIME_NS  2000000
`define NV_CLK_PERIOD_NS  25
`define NV_WRITE_CYCLES \
  ((`NV_WRITE_TIME_NS + `NV_CLK_PERIOD_NS - 1) / `NV_CLK_PERIOD_NS)

`endif

// ### logic/nv_pkg.sv
// Types shared by the nonvolatile self-access block.
// Assumes nothing beyond a SystemVerilog compiler.
package nv_pkg;

  // Controller state
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_PROG = 1'b1
  } nv_state_t;

  // Kind of self-timed operation in flight
  typedef enum logic [1:0] {
    OP_DATA  = 2'b00,
    OP_ERASE = 2'b01,
    OP_BLOCK = 2'b10
  } nv_op_t;

  // Progress through the unlock key pair
  typedef enum logic [1:0] {
    UL_NONE  = 2'b00,
    UL_FIRST = 2'b01,
    UL_ARMED = 2'b10
  } nv_unlock_t;

endpackage

// ### logic/nv_write_timer.sv
// Self-timed write/erase interval counter.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/1ps
module nv_write_timer #(
  parameter int CYCLES = 80000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_ff;

  initial begin
    if (CYCLES < 1) $error("nv_write_timer: CYCLES must be at least 1");
  end

  // Load on start, count down; done pulses on the last cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else if (start) begin
      cnt_ff <= CW'(CYCLES);
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - CW'(1);
    end
  end

  assign busy = (cnt_ff != '0);
  assign done = (cnt_ff == CW'(1));
endmodule

// ### logic/nv_memory_self_access.sv
// Processor self-access controller for the data EEPROM and program Flash.
// Assumes an APB master on pclk, presetn for core resets (pin or watchdog)
// and por_n for power-on only; arrays are flip-flops standing in for cells.
//
// Behaviour
// RULE_01: Both arrays reachable at run time only through the access registers.
// RULE_02: Data access uses low data byte and low address byte, 256 places.
// RULE_03: Small variant: upper data half reads zero; writes there stop the pump.
// RULE_04: Program access uses 14-bit word and 13-bit word address pairs.
// RULE_05: Program addresses past the array wrap to its start.
// RULE_06: Data byte write erases then programs one location.
// RULE_07: Program reads single words; writes in 4-word blocks after row erase.
// RULE_08: Every write or erase is self-timed; pump supplies the voltage.
// RULE_09: Code protection keeps CPU access; write protect may block blocks.
// RULE_10: Code protection denies the external programmer both arrays.
// RULE_11: Software loads only needed address bytes for each space.
// RULE_12: Address bits above the array size are not implemented.
// RULE_13: Space select: clear data, set program; clear after reset.
// RULE_14: Read and write start bits set by software, cleared by hardware.
// RULE_15: Writes proceed only with the enable gate set; clear at power-up.
// RULE_16: A reset that cuts a write short raises the abort error flag.
// RULE_17: Data and address registers survive such a reset.
// RULE_18: Completion sets the done flag; only software clears it.
// RULE_19: Unlock register stores nothing and reads zero.
// RULE_20: Done interrupt enable sits at bit 4 and gates the interrupt.
// RULE_21: Done flag sets regardless of any enable.
// RULE_22: Write starts only right after the unlock key pair.
// RULE_23: Program words buffer; block programs after its last word.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "nv_consts.svh"
module nv_memory_self_access
  import nv_pkg::*;
#(
  parameter int DATA_IMPL    = 256,
  parameter int PROG_WORDS   = 2048,
  parameter int WRITE_CYCLES = `NV_WRITE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        code_protect,
  input  wire logic        prog_write_protect,
  input  wire logic        ext_prog_req,
  input  wire logic        ext_prog_space,
  input  wire logic [12:0] ext_prog_addr,
  output logic      [13:0] ext_prog_data,
  output logic             ext_prog_denied,
  output logic             charge_pump_on,
  output logic             write_irq
);
  localparam int PA_W = $clog2(PROG_WORDS);
  localparam int AH_W = PA_W - 8;
  localparam int DW   = `NV_DATA_WIDTH;
  localparam int PW   = `NV_PWORD_WIDTH;
  initial begin
    if (DATA_IMPL != 128 && DATA_IMPL != 256)
      $error("DATA_IMPL must be 128 or 256");
    if (PROG_WORDS != 1024 && PROG_WORDS != 2048)
      $error("PROG_WORDS must be 1024 or 2048");
  end

  // Storage, never on the register map
  logic [DW-1:0] dmem [0:255];                          // RULE_01
  logic [PW-1:0] pmem [0:PROG_WORDS-1];
  logic [PW-1:0] blk_buf [0:`NV_BLOCK_WORDS-1];

  logic [DW-1:0]   data_low_ff;
  logic [PW-DW-1:0] data_high_ff;
  logic [7:0]      addr_low_ff;
  logic [AH_W-1:0] addr_high_ff;
  logic            space_ff, erase_ff, gate_ff, rd_ff, wr_ff;
  logic            abort_ff, in_prog_ff, done_flag_ff, irq_en_ff;
  logic            pump_off_ff;
  nv_state_t       state_ff;
  nv_op_t          op_ff;
  nv_unlock_t      unlock_ff;
  logic [PA_W-1:0] op_addr_ff;
  logic [DW-1:0]   op_dat_ff;
  logic [31:0]     prdata_ff, rd_mux;
  logic [7:0]      ctl_view;

  logic            setup, wr_acc, hit, ctl_wr, wr_req, start_ok;
  logic            new_space, new_erase, blocked, d_unimpl, last_word;
  logic            go_timed, tmr_busy, tmr_done;
  logic [PA_W-1:0] p_addr;

  // APB decode; always zero wait
  assign setup   = psel & ~penable;
  assign wr_acc  = psel & penable & pwrite;
  assign hit     = (paddr[1:0] == 2'b00) && (paddr <= `NV_OFS_ENABLE2);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_ff;

  // Program address keeps only implemented bits, so it wraps
  assign p_addr   = {addr_high_ff, addr_low_ff};       // RULE_04 RULE_05
  assign d_unimpl = ({1'b0, addr_low_ff} >= 9'(DATA_IMPL)); // RULE_03

  // Write start decode, using the space bits written with it
  assign ctl_wr    = wr_acc && (paddr == `NV_OFS_CONTROL);
  assign new_space = pwdata[`NV_CTL_SPACE];
  assign new_erase = pwdata[`NV_CTL_ERASE];
  assign wr_req    = ctl_wr && pwdata[`NV_CTL_WR_START];
  assign blocked   = new_space & code_protect & prog_write_protect; // RULE_09
  assign start_ok  = wr_req && (unlock_ff == UL_ARMED) // RULE_22
                   && gate_ff                          // RULE_15
                   && (state_ff == ST_IDLE) && !tmr_busy && !wr_ff && !blocked;
  assign last_word = (p_addr[1:0] == 2'(`NV_BLOCK_WORDS - 1));
  // Non-final program words only buffer; no timed cycle
  assign go_timed  = start_ok && (!new_space || new_erase || last_word);

  nv_write_timer #(
    .CYCLES (WRITE_CYCLES)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (go_timed),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  // Unlock keys: any other write in between disarms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_ff <= UL_NONE;
    end else if (wr_acc) begin
      if (paddr != `NV_OFS_UNLOCK)
        unlock_ff <= UL_NONE;                          // RULE_22
      else if (pwdata[7:0] == `NV_KEY_FIRST)
        unlock_ff <= UL_FIRST;
      else if (pwdata[7:0] == `NV_KEY_SECOND && unlock_ff == UL_FIRST)
        unlock_ff <= UL_ARMED;
      else
        unlock_ff <= UL_NONE;
    end
  end

  // Control bits; start bits cannot be cleared by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      space_ff <= 1'b0;                                // RULE_13
      erase_ff <= 1'b0;
      gate_ff  <= 1'b0;                                // RULE_15
      rd_ff    <= 1'b0;
      wr_ff    <= 1'b0;
    end else begin
      if (ctl_wr) begin
        space_ff <= new_space;                         // RULE_13
        erase_ff <= new_erase;
        gate_ff  <= pwdata[`NV_CTL_GATE];
      end
      // Read takes one cycle, then hardware drops the bit
      rd_ff <= !rd_ff && ctl_wr && pwdata[`NV_CTL_RD_START]; // RULE_14
      wr_ff <= go_timed || (wr_ff && !tmr_done);       // RULE_14
    end
  end

  // Timed operation state and its captured arguments
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= ST_IDLE;
      op_ff       <= OP_DATA;
      op_addr_ff  <= '0;
      op_dat_ff   <= '0;
      pump_off_ff <= 1'b0;
    end else if (go_timed) begin
      state_ff   <= ST_PROG;                           // RULE_08
      op_addr_ff <= new_space ? p_addr : PA_W'(addr_low_ff);
      op_dat_ff  <= data_low_ff;
      // Unimplemented data place: run the cycle with the pump off
      pump_off_ff <= !new_space && d_unimpl;           // RULE_03
      op_ff <= !new_space ? OP_DATA
             : (new_erase ? OP_ERASE : OP_BLOCK);      // RULE_23
    end else if (tmr_done) begin
      state_ff <= ST_IDLE;
    end
  end

  assign charge_pump_on = (state_ff == ST_PROG) && !pump_off_ff; // RULE_08
  // Word buffer fills on each accepted program write request
  always_ff @(posedge pclk) begin
    if (start_ok && new_space && !new_erase)
      blk_buf[p_addr[1:0]] <= {data_high_ff, data_low_ff}; // RULE_23
  end

  // Commit at the end of the timed interval
  always_ff @(posedge pclk) begin
    if (tmr_done) begin
      unique case (op_ff)
        OP_DATA: begin
          // Single cell overwritten: erase and program in one go
          if (!pump_off_ff)
            dmem[op_addr_ff[7:0]] <= op_dat_ff;        // RULE_06
        end
        OP_ERASE: begin
          for (int i = 0; i < `NV_ROW_WORDS; i++)
            pmem[{op_addr_ff[PA_W-1:5], 5'(i)}] <= `NV_ERASED_WORD; // RULE_07
        end
        OP_BLOCK: begin
          for (int i = 0; i < `NV_BLOCK_WORDS; i++)
            pmem[{op_addr_ff[PA_W-1:2], 2'(i)}] <= blk_buf[i]; // RULE_07
        end
        default: ;
      endcase
    end
  end

  // Data and address registers: power-on reset only, so they ride out
  // a core reset that interrupts a write
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      data_low_ff  <= '0;
      data_high_ff <= '0;
      addr_low_ff  <= '0;
      addr_high_ff <= '0;
    end else begin
      if (rd_ff) begin
        if (space_ff) begin
          data_low_ff  <= pmem[p_addr][DW-1:0];        // RULE_04
          data_high_ff <= pmem[p_addr][PW-1:DW];
        end else begin
          data_low_ff <= d_unimpl ? '0 : dmem[addr_low_ff]; // RULE_02 RULE_03
        end
      end else if (wr_acc) begin
        unique case (paddr)
          `NV_OFS_DATA_LOW:  data_low_ff  <= pwdata[DW-1:0];   // RULE_17
          `NV_OFS_DATA_HIGH: data_high_ff <= pwdata[PW-DW-1:0];
          `NV_OFS_ADDR_LOW:  addr_low_ff  <= pwdata[7:0];
          `NV_OFS_ADDR_HIGH: addr_high_ff <= pwdata[AH_W-1:0]; // RULE_12
          default: ;
        endcase
      end
    end
  end

  // Abort detection: an operation marked in flight while the core-reset
  // controller sits idle can only mean a reset cut it short
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      in_prog_ff <= 1'b0;
      abort_ff   <= 1'b0;
    end else begin
      if (go_timed)
        in_prog_ff <= 1'b1;
      else if (tmr_done || (in_prog_ff && state_ff == ST_IDLE))
        in_prog_ff <= 1'b0;
      // Set wins over a software clear in the same cycle
      if (in_prog_ff && state_ff == ST_IDLE)
        abort_ff <= 1'b1;                              // RULE_16
      else if (presetn && ctl_wr)
        abort_ff <= pwdata[`NV_CTL_ABORT_ERR];
    end
  end

  // Done flag and its enable; hardware only sets the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag_ff <= 1'b0;
      irq_en_ff    <= 1'b0;
    end else begin
      if (tmr_done)
        done_flag_ff <= 1'b1;                          // RULE_18 RULE_21
      else if (wr_acc && paddr == `NV_OFS_FLAG2)
        done_flag_ff <= pwdata[`NV_DONE_BIT];
      if (wr_acc && paddr == `NV_OFS_ENABLE2)
        irq_en_ff <= pwdata[`NV_DONE_BIT];             // RULE_20
    end
  end

  assign write_irq = done_flag_ff & irq_en_ff;         // RULE_20
  // Control register as read back
  always_comb begin
    ctl_view = 8'h00;
    ctl_view[`NV_CTL_RD_START]  = rd_ff;
    ctl_view[`NV_CTL_WR_START]  = wr_ff;
    ctl_view[`NV_CTL_GATE]      = gate_ff;
    ctl_view[`NV_CTL_ABORT_ERR] = abort_ff;
    ctl_view[`NV_CTL_ERASE]     = erase_ff;
    ctl_view[`NV_CTL_SPACE]     = space_ff;
  end

  // Read mux; unlock register and unmapped words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `NV_OFS_DATA_LOW:  rd_mux[DW-1:0]    = data_low_ff;
      `NV_OFS_DATA_HIGH: rd_mux[PW-DW-1:0] = data_high_ff;
      `NV_OFS_ADDR_LOW:  rd_mux[7:0]       = addr_low_ff;
      `NV_OFS_ADDR_HIGH: rd_mux[AH_W-1:0]  = addr_high_ff; // RULE_12
      `NV_OFS_CONTROL:   rd_mux[7:0]       = ctl_view;
      `NV_OFS_UNLOCK:    rd_mux            = 32'h0000_0000; // RULE_19
      `NV_OFS_FLAG2:     rd_mux[`NV_DONE_BIT] = done_flag_ff;
      `NV_OFS_ENABLE2:   rd_mux[`NV_DONE_BIT] = irq_en_ff;
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup cycle, held through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata_ff <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata_ff <= rd_mux;
  end

  // External serial programmer read port, shut out by code protection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prog_data   <= '0;
      ext_prog_denied <= 1'b0;
    end else if (ext_prog_req) begin
      ext_prog_denied <= code_protect;                 // RULE_10
      if (code_protect)
        ext_prog_data <= '0;
      else if (ext_prog_space)
        ext_prog_data <= pmem[ext_prog_addr[PA_W-1:0]];
      else
        ext_prog_data <= {6'h00, dmem[ext_prog_addr[7:0]]};
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_keys_then_start;
    (unlock_ff == UL_ARMED) ##0 wr_req;
  endsequence

  AST_UNLOCK_NEEDED: assert property ( // RULE_22
    $rose(state_ff == ST_PROG) |-> $past(unlock_ff == UL_ARMED && wr_req))
    else $error("timed write started without unlock keys");
  AST_GATE_NEEDED: assert property ( // RULE_15
    s_keys_then_start ##0 (!gate_ff && state_ff == ST_IDLE)
      |=> state_ff == ST_IDLE)
    else $error("write started with enable gate clear");
  AST_WR_HELD: assert property ( // RULE_14
    (state_ff == ST_PROG) && !tmr_done |=> wr_ff)
    else $error("write start bit dropped during write");
  AST_RD_SELF_CLEAR: assert property ( // RULE_14
    rd_ff |=> !rd_ff)
    else $error("read start bit not cleared by hardware");
  AST_DONE_SET: assert property ( // RULE_18
    tmr_done |=> done_flag_ff && wr_ff == 1'b0 && state_ff == ST_IDLE)
    else $error("completion did not set done flag");
  AST_PUMP_OFF: assert property ( // RULE_03
    (state_ff == ST_PROG) && pump_off_ff |-> !charge_pump_on)
    else $error("pump on for unimplemented data place");
  AST_UNIMPL_ZERO: assert property ( // RULE_03
    rd_ff && !space_ff && d_unimpl |=> data_low_ff == 8'h00)
    else $error("unimplemented data place read nonzero");
  AST_UNLOCK_ZERO: assert property ( // RULE_19
    setup && !pwrite && paddr == `NV_OFS_UNLOCK |=> prdata == 32'h0)
    else $error("unlock register read nonzero");
  AST_EXT_DENIED: assert property ( // RULE_10
    ext_prog_req && code_protect |=> ext_prog_denied && ext_prog_data == '0)
    else $error("programmer not denied under protection");
  AST_IRQ_GATE: assert property ( // RULE_20
    write_irq |-> done_flag_ff && irq_en_ff)
    else $error("interrupt without flag and enable");
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the nonvolatile self-access controller.
// Assumes nv_consts.svh on the include path; small array variant.
`timescale 1ns/1ps
`include "nv_consts.svh"
module testbench
  import nv_pkg::*;
;
  localparam int        WC    = 8;
  localparam logic [7:0] A_DL  = `NV_OFS_DATA_LOW;
  localparam logic [7:0] A_DH  = `NV_OFS_DATA_HIGH;
  localparam logic [7:0] A_AL  = `NV_OFS_ADDR_LOW;
  localparam logic [7:0] A_AH  = `NV_OFS_ADDR_HIGH;
  localparam logic [7:0] A_CTL = `NV_OFS_CONTROL;
  localparam logic [7:0] A_UL  = `NV_OFS_UNLOCK;
  localparam logic [7:0] A_FL  = `NV_OFS_FLAG2;
  localparam logic [7:0] A_EN  = `NV_OFS_ENABLE2;

  logic        pclk = 1'b0;
  logic        presetn, por_n, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, code_protect, prog_write_protect;
  logic        ext_prog_req, ext_prog_space, ext_prog_denied;
  logic        charge_pump_on, write_irq;
  logic [12:0] ext_prog_addr;
  logic [13:0] ext_prog_data;
  logic [31:0] exp_q[$];
  logic [31:0] rnd = 32'he4e37d6c;
  logic [13:0] w[4];
  logic [7:0]  b;
  int          mismatches = 0;
  int          checks = 0;

  // Short write time keeps the run brief
  nv_memory_self_access #(.DATA_IMPL(128), .PROG_WORDS(1024),
    .WRITE_CYCLES(WC)) dut (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .code_protect(code_protect), .prog_write_protect(prog_write_protect),
    .ext_prog_req(ext_prog_req), .ext_prog_space(ext_prog_space),
    .ext_prog_addr(ext_prog_addr), .ext_prog_data(ext_prog_data),
    .ext_prog_denied(ext_prog_denied), .charge_pump_on(charge_pump_on),
    .write_irq(write_irq));

  // 40 MHz
  always #12.5 pclk = ~pclk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic wr,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  // Expectation is queued before the read goes out
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    apb(a, 1'b0, 32'h0);
  endtask

  // Program access loads both address bytes, data access the low one only
  task automatic load(input logic [12:0] a, input logic [13:0] d,
                      input logic sp);
    if (sp) wr(A_AH, {27'h0, a[12:8]});
    wr(A_AL, {24'h0, a[7:0]});
    if (sp) wr(A_DH, {26'h0, d[13:8]});
    wr(A_DL, {24'h0, d[7:0]});
  endtask

  // Key pair then the start write, nothing in between
  task automatic kick(input logic [7:0] ctl);
    wr(A_UL, {24'h0, `NV_KEY_FIRST});
    wr(A_UL, {24'h0, `NV_KEY_SECOND});
    wr(A_CTL, {24'h0, ctl});
  endtask

  // Read operation; high byte only meaningful for program space
  task automatic fetch(input logic [12:0] a, input logic [7:0] ctl,
                       input logic [13:0] exp);
    if (ctl[7]) wr(A_AH, {27'h0, a[12:8]});
    wr(A_AL, {24'h0, a[7:0]});
    wr(A_CTL, {24'h0, ctl});
    if (ctl[7]) rd(A_DH, {26'h0, exp[13:8]});
    rd(A_DL, {24'h0, exp[7:0]});
  endtask

  task automatic ext_rd(input logic [12:0] a, input logic sp);
    @(posedge pclk);
    ext_prog_req <= 1'b1;
    ext_prog_space <= sp;
    ext_prog_addr <= a;
    @(posedge pclk);
    ext_prog_req <= 1'b0;
    @(negedge pclk);
  endtask

  // Monitor: pops the oldest note at each completed read
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      check({31'h0, pslverr}, {31'h0, paddr > 8'h1c});
      if (pwrite === 1'b0 && exp_q.size() > 0) begin
        check(prdata, exp_q.pop_front());
      end
    end
  end

  // Watchdog, well past the expected run length
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    por_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    code_protect = 1'b0;
    prog_write_protect = 1'b0;
    ext_prog_req = 1'b0;
    ext_prog_space = 1'b0;
    ext_prog_addr = 13'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    // Reset values, unlock place, unmapped place
    rd(A_CTL, 32'h0);
    wr(A_UL, 32'h55);
    rd(A_UL, 32'h0);
    rd(A_FL, 32'h0);
    rd(8'h20, 32'h0);
    // Keyed start with the gate still clear is ignored
    rnd = xs(rnd);
    b = rnd[7:0];
    load(13'h010, {6'h0, b}, 1'b0);
    kick(8'h02);
    repeat (WC + 4) @(posedge pclk);
    rd(A_FL, 32'h0);
    // Gate set but no keys: ignored
    wr(A_CTL, 32'h04);
    wr(A_CTL, 32'h06);
    rd(A_CTL, 32'h04);
    // Real byte write; software cannot cut it short
    kick(8'h06);
    repeat (2) @(negedge pclk);
    check({31'h0, charge_pump_on}, 32'h1);
    wr(A_CTL, 32'h04);
    rd(A_CTL, 32'h06);
    repeat (WC + 4) @(posedge pclk);
    rd(A_FL, 32'h10);
    check({31'h0, write_irq}, 32'h0);
    rd(A_CTL, 32'h04);
    wr(A_EN, 32'h10);
    @(negedge pclk);
    check({31'h0, write_irq}, 32'h1);
    wr(A_DL, 32'h0);
    fetch(13'h010, 8'h05, {6'h0, b});
    rd(A_FL, 32'h10);
    wr(A_FL, 32'h0);
    rd(A_FL, 32'h0);
    // Upper half absent on the small part
    load(13'h085, 14'h0a5, 1'b0);
    kick(8'h06);
    repeat (2) @(negedge pclk);
    check({31'h0, charge_pump_on}, 32'h0);
    rd(A_CTL, 32'h06);
    repeat (WC + 4) @(posedge pclk);
    fetch(13'h085, 8'h05, 14'h0);
    // Row erase, then one buffered four-word block
    load(13'h040, 14'h0, 1'b1);
    kick(8'h96);
    repeat (WC + 4) @(posedge pclk);
    for (int k = 0; k < 4; k++) begin
      rnd = xs(rnd);
      w[k] = rnd[13:0];
      load(13'h040 + 13'(k), w[k], 1'b1);
      kick(8'h86);
      if (k < 3) rd(A_CTL, 32'h84);
    end
    repeat (WC + 4) @(posedge pclk);
    // Addresses past 1K words wrap to the start
    for (int k = 0; k < 4; k++) begin
      fetch(13'h440 + 13'(k), 8'h85, w[k]);
    end
    // Only two high address bits exist on the 1K-word part
    wr(A_AH, 32'h1f);
    rd(A_AH, 32'h03);
    fetch(13'h044, 8'h85, 14'h3fff);
    // Protection: block write refused, CPU reads kept
    code_protect <= 1'b1;
    prog_write_protect <= 1'b1;
    load(13'h047, 14'h1234, 1'b1);
    kick(8'h86);
    rd(A_CTL, 32'h84);
    fetch(13'h041, 8'h85, w[1]);
    ext_rd(13'h040, 1'b1);
    check({31'h0, ext_prog_denied}, 32'h1);
    check({18'h0, ext_prog_data}, 32'h0);
    @(posedge pclk);
    code_protect <= 1'b0;
    ext_rd(13'h040, 1'b1);
    check({31'h0, ext_prog_denied}, 32'h0);
    check({18'h0, ext_prog_data}, {18'h0, w[0]});
    ext_rd(13'h010, 1'b0);
    check({18'h0, ext_prog_data}, {24'h0, b});
    repeat (WC + 4) @(posedge pclk);
    fetch(13'h047, 8'h85, 14'h3fff);
    // Core reset in mid-write: error flag, regs kept
    load(13'h020, 14'h05a, 1'b0);
    kick(8'h06);
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(A_CTL, 32'h08);
    rd(A_AL, 32'h20);
    rd(A_DL, 32'h5a);
    repeat (2) @(posedge pclk);
    end_sim();
  end
endmodule
